// ---- core/dspe_pkg.sv ----
`default_nettype none
package dspe_pkg;
  localparam int PKT_BITS = 17;
  localparam int STATUS_POS = 16;
  localparam int DATA_MSB = 15;
  localparam logic [15:0] RESP_OK_DATA = 16'hFFFF;
  localparam logic [15:0] RESP_NOT_READY_DATA = 16'h0000;
  localparam logic [15:0] RESP_BUS_ERR_DATA = 16'h0001;
  localparam logic [15:0] RESP_ILLEGAL_DATA = 16'hFFFF;
  localparam int RECOVERY_CLKS = 32;
  localparam logic [16:0] PKT_RESET = 17'h00000;

  typedef enum logic [2:0] {
    DSPE_RESP_DATA,
    DSPE_RESP_OK,
    DSPE_RESP_NOT_READY,
    DSPE_RESP_BUS_ERR,
    DSPE_RESP_ILLEGAL
  } dspe_resp_t;
endpackage
`default_nettype wire

// ---- core/dspe_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module dspe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= i_async;
      stage2 <= stage1;
    end
  end

  assign o_sync = stage2;
endmodule
`default_nettype wire

// ---- core/dspe_packet_exchange.sv ----
// Overview of operation
// - Every response is one 17-bit packet with status in bit 16 and data in bits 15 to 0.
// - Status clear carries valid data, and status clear with all-ones data is a plain OK.
// - A result not yet available is answered with status set and all-zero data.
// - A debug bus cycle ending in a termination error is answered with status set and data one.
// - An unrecognised command is answered with status set and all-ones data.
// - Outside a memory cycle the port is ready again 32 clocks after a transfer ends.
`timescale 1ns/1ps
`default_nettype none
module dspe_packet_exchange (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_dsclk,
  input wire logic i_dsi,
  output logic o_dso,
  output logic o_ready,
  output logic o_rx_valid,
  output logic [15:0] o_rx_data,
  output logic o_rx_ctrl,
  input wire logic i_resp_valid,
  input wire dspe_pkg::dspe_resp_t i_resp_kind,
  input wire logic [15:0] i_resp_data,
  input wire logic i_mem_busy,
  output logic o_resp_taken
);
  ////////////////////////////////////////////////////////////////////////
  logic [1:0] pin_sync;
  logic dsclk_s;
  logic dsi_s;
  logic dsclk_d;

  // Pins come from the host's domain
  dspe_sync #(.WIDTH(2)) u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_dsclk, i_dsi}),
    .o_sync(pin_sync)
  );
  assign dsclk_s = pin_sync[1];
  assign dsi_s = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////
  logic [16:0] tx_shift;
  logic [16:0] rx_shift;
  logic [4:0] bit_cnt;
  logic [5:0] rec_cnt;
  logic rx_valid;
  logic [16:0] rx_word;
  logic dso;
  logic [16:0] next_tx_shift;
  logic [16:0] next_rx_shift;
  logic [4:0] next_bit_cnt;
  logic [5:0] next_rec_cnt;
  logic next_rx_valid;
  logic [16:0] next_rx_word;
  logic next_dso;
  logic [16:0] resp_pkt;
  logic rise;
  logic fall;
  logic resp_take;
  logic pkt_done;
  logic next_dsclk_d;
  logic tx_fresh;
  logic next_tx_fresh;

  assign rise = dsclk_s & ~dsclk_d;
  assign fall = ~dsclk_s & dsclk_d;

  // Encode the one response word
  always_comb
  begin
    unique case (i_resp_kind)
      dspe_pkg::DSPE_RESP_DATA: resp_pkt = {1'b0, i_resp_data};
      dspe_pkg::DSPE_RESP_OK: resp_pkt = {1'b0, dspe_pkg::RESP_OK_DATA};
      dspe_pkg::DSPE_RESP_NOT_READY: resp_pkt = {1'b1, dspe_pkg::RESP_NOT_READY_DATA};
      dspe_pkg::DSPE_RESP_BUS_ERR: resp_pkt = {1'b1, dspe_pkg::RESP_BUS_ERR_DATA};
      dspe_pkg::DSPE_RESP_ILLEGAL: resp_pkt = {1'b1, dspe_pkg::RESP_ILLEGAL_DATA};
      default: resp_pkt = {1'b1, dspe_pkg::RESP_ILLEGAL_DATA};
    endcase
  end

  // Response latched only between packets, so a word never tears mid-shift
  assign resp_take = (bit_cnt == 5'h00) && !rise && !fall;
  // Last rising edge of a packet
  assign pkt_done = rise && (bit_cnt == 5'(dspe_pkg::PKT_BITS - 1));

  ////////////////////////////////////////////////////////////////////////
  // Edge detect, idles low like the pin
  always_comb
  begin
    next_dsclk_d = dsclk_s;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      dsclk_d <= 1'b0;
    end
    else
    begin
      dsclk_d <= next_dsclk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift state
  always_comb
  begin
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_bit_cnt = bit_cnt;
    next_dso = dso;
    if (resp_take)
    begin
      // Without a fresh answer the port says not ready
      next_tx_shift = i_resp_valid ? resp_pkt
                    : {1'b1, dspe_pkg::RESP_NOT_READY_DATA};
      next_dso = next_tx_shift[dspe_pkg::STATUS_POS];
    end
    if (rise)
    begin
      next_rx_shift = {rx_shift[15:0], dsi_s};
      next_bit_cnt = pkt_done ? 5'h00 : bit_cnt + 5'h01;
    end
    if (fall && bit_cnt != 5'h00)
    begin
      next_tx_shift = {tx_shift[15:0], 1'b0};
      next_dso = tx_shift[15];
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tx_shift <= dspe_pkg::PKT_RESET;
      rx_shift <= dspe_pkg::PKT_RESET;
      bit_cnt <= 5'h00;
      dso <= 1'b0;
    end
    else
    begin
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      bit_cnt <= next_bit_cnt;
      dso <= next_dso;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Received word
  always_comb
  begin
    next_rx_valid = pkt_done;
    next_rx_word = rx_word;
    if (pkt_done)
    begin
      next_rx_word = {rx_shift[15:0], dsi_s};
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rx_valid <= 1'b0;
      rx_word <= dspe_pkg::PKT_RESET;
    end
    else
    begin
      rx_valid <= next_rx_valid;
      rx_word <= next_rx_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Recovery count
  always_comb
  begin
    next_rec_cnt = rec_cnt;
    if (rec_cnt != 6'h00)
    begin
      next_rec_cnt = rec_cnt - 6'h01;
    end
    if (pkt_done)
    begin
      // Memory cycles hold the port busy instead of the fixed recovery
      next_rec_cnt = i_mem_busy ? 6'h00 : 6'(dspe_pkg::RECOVERY_CLKS);
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rec_cnt <= 6'h00;
    end
    else
    begin
      rec_cnt <= next_rec_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Offered answer; taken is reported once per packet, not each idle cycle
  always_comb
  begin
    next_tx_fresh = tx_fresh;
    if (resp_take)
    begin
      next_tx_fresh = i_resp_valid;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tx_fresh <= 1'b0;
    end
    else
    begin
      tx_fresh <= next_tx_fresh;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_dso = dso;
  assign o_ready = (rec_cnt == 6'h00) && !i_mem_busy && (bit_cnt == 5'h00);
  assign o_rx_valid = rx_valid;
  assign o_rx_data = rx_word[dspe_pkg::DATA_MSB:0];
  // Control bit passed up as sent; host must send zero
  assign o_rx_ctrl = rx_word[dspe_pkg::STATUS_POS];
  // Committed at the first rising edge, when the word can no longer change
  assign o_resp_taken = rise && (bit_cnt == 5'h00) && tx_fresh;
endmodule
`default_nettype wire

// ---- tb/dspe_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dspe_sva (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_mem_busy,
  input wire logic o_ready,
  input wire logic o_rx_valid,
  input wire logic o_rx_ctrl,
  input wire logic [15:0] o_rx_data,
  input wire logic o_resp_taken
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  a_ready_held: assert property (o_rx_valid |=> !o_ready [*8]) else $error("ready early");
  a_ready_back: assert property (o_rx_valid && !i_mem_busy |-> ##[31:34] (o_ready || i_mem_busy))
    else $error("ready late");
  a_ready_gap: assert property ($fell(o_ready) && !i_mem_busy |-> !o_ready [*8])
    else $error("short gap");
  a_busy_block: assert property (i_mem_busy |-> !o_ready) else $error("ready in busy");
  a_ready_rise: assert property ($rose(o_ready) |-> !i_mem_busy) else $error("bad rise");
  a_rx_pulse: assert property (o_rx_valid |=> !o_rx_valid) else $error("long pulse");
  a_rx_hold: assert property ($changed({o_rx_ctrl, o_rx_data}) |-> o_rx_valid || $past(o_rx_valid))
    else $error("rx moved");
  a_taken_pulse: assert property (o_resp_taken |=> !o_resp_taken) else $error("taken twice");
endmodule
bind dspe_packet_exchange dspe_sva i_sva (.i_mclk, .i_sys_rst, .i_mem_busy, .o_ready,
  .o_rx_valid, .o_rx_ctrl, .o_rx_data, .o_resp_taken);
`default_nettype wire

// ---- tb/dspe_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module dspe_host (
  input wire logic i_mclk,
  input wire logic i_dso,
  output logic o_dsclk,
  output logic o_dsi
);
  initial o_dsclk = 0;
  initial o_dsi = 0;
  // Five clocks high and six low a phase gives the synchroniser margin
  task xfer(input logic [16:0] tx, output logic [16:0] rx);
    for (int b = 16; b >= 0; b--)
    begin
      @(negedge i_mclk);
      o_dsi = tx[b];
      repeat (5) @(negedge i_mclk);
      o_dsclk = 1;
      rx[b] = i_dso;
      repeat (5) @(negedge i_mclk);
      o_dsclk = 0;
    end
    o_dsi = ~o_dsi;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {dspe_pkg::dspe_resp_t k; logic [15:0] d; logic [16:0] e;} dspe_row_t;
  logic clk = 0, rst = 1, rv = 0, busy = 0, dsclk, dsi, dso, rdy, rxv, rxc, tkn;
  logic [15:0] rxd, rd = 16'h0000;
  logic [16:0] got;
  dspe_pkg::dspe_resp_t kind = dspe_pkg::DSPE_RESP_DATA;
  int miscompares = 0, tests_run = 0, i, taken_cnt = 0;
  dspe_row_t rows [5] = '{'{dspe_pkg::DSPE_RESP_DATA, 16'h1234, 17'h01234},
    '{dspe_pkg::DSPE_RESP_OK, 16'h0000, 17'h0FFFF},
    '{dspe_pkg::DSPE_RESP_NOT_READY, 16'h0000, 17'h10000},
    '{dspe_pkg::DSPE_RESP_BUS_ERR, 16'h0000, 17'h10001},
    '{dspe_pkg::DSPE_RESP_ILLEGAL, 16'h0000, 17'h1FFFF}};
  initial forever #12.5 clk = ~clk;
  dspe_host i_host (.i_mclk(clk), .i_dso(dso), .o_dsclk(dsclk), .o_dsi(dsi));
  dspe_packet_exchange i_dut (.i_mclk(clk), .i_sys_rst(rst), .i_dsclk(dsclk), .i_dsi(dsi),
    .o_dso(dso), .o_ready(rdy), .o_rx_valid(rxv), .o_rx_data(rxd), .o_rx_ctrl(rxc),
    .i_resp_valid(rv), .i_resp_kind(kind), .i_resp_data(rd), .i_mem_busy(busy),
    .o_resp_taken(tkn));
  always @(posedge clk) if (tkn === 1'b1) taken_cnt++;
  //////////////////////////////////////////////////
  task conclude;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [16:0] g, input logic [16:0] e);
    tests_run++;
    miscompares += int'(g !== e);
    if (g !== e) $display("Error %0t got %h exp %h", $time, g, e);
  endtask
  task run(input logic [16:0] tx, input logic [16:0] exp);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    miscompares += int'(n == 200);
    if (n == 200) conclude();
    i_host.xfer(tx, got);
    chk(got, exp);
    chk({rxc, rxd}, tx);
    chk({16'h0000, rdy}, 17'h00000);
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    chk({16'h0000, rdy}, 17'h00001);
    rst = 0;
    repeat (4) @(negedge clk);
    rv = 1;
    for (i = 0; i < 5; i++)
    begin
      kind = rows[i].k;
      rd = rows[i].d;
      repeat (3) @(negedge clk);
      run(17'h0A5C3 + 17'(i), rows[i].e);
      $display("row %0d done", i);
    end
    chk(17'(taken_cnt), 17'h00005);
    $display("table done");
    rv = 0;
    run(17'h0FFFF, 17'h10000);
    chk(17'(taken_cnt), 17'h00005);
    busy = 1;
    repeat (60) @(negedge clk);
    chk({16'h0000, rdy}, 17'h00000);
    i_host.xfer(17'h00042, got);
    chk(got, 17'h10000);
    chk({rxc, rxd}, 17'h00042);
    repeat (10) @(negedge clk);
    busy = 0;
    @(negedge clk);
    chk({16'h0000, rdy}, 17'h00001);
    $display("busy done");
    conclude();
  end
endmodule
`default_nettype wire
